// *** logic/fpd_consts.svh ***
// Constants for the floating-point instruction field decoder and its host
`ifndef FPD_CONSTS_SVH
`define FPD_CONSTS_SVH

// Identification bytes of the two coprocessor instruction formats
`define FPD_ID_FMT9     8'h3E
`define FPD_ID_FMT11    8'hBE

// Status codes on the link
`define FPD_ST_ID       2'h3
`define FPD_ST_OPND     2'h1

// Operation word field positions
`define FPD_G1_MSB      15
`define FPD_G1_LSB      11
`define FPD_G2_MSB      10
`define FPD_G2_LSB      6
`define FPD_OP9_MSB     5
`define FPD_OP9_LSB     3
`define FPD_OP11_MSB    5
`define FPD_OP11_LSB    2
`define FPD_F9_BIT      2
`define FPD_F11_BIT     0
`define FPD_I_MSB       1
`define FPD_I_LSB       0

// General operand mode codes
`define FPD_MODE_REG_MAX   5'h07
`define FPD_MODE_IMM       5'h14
`define FPD_MODE_RSVD      5'h13
`define FPD_MODE_SCALE_MIN 5'h1C

// Integer size field and precision bit
`define FPD_I_BYTE      2'h0
`define FPD_I_WORD      2'h1
`define FPD_I_D2S       2'h2
`define FPD_I_DWORD     2'h3
`define FPD_F_SINGLE    1'h1
`define FPD_F_DOUBLE    1'h0

// Format 9 op codes
`define FPD_OP9_I2F     3'h0
`define FPD_OP9_FSR_LD  3'h1
`define FPD_OP9_D2S     3'h2
`define FPD_OP9_S2D     3'h3
`define FPD_OP9_RND     3'h4
`define FPD_OP9_TRN     3'h5
`define FPD_OP9_FSR_ST  3'h6
`define FPD_OP9_FLR     3'h7

// Format 11 op codes
`define FPD_OP11_COPY   4'h1
`define FPD_OP11_CMP    4'h2
`define FPD_OP11_ILL_A  4'h3
`define FPD_OP11_ILL_B  4'h9

// Trap type codes
`define FPD_TRAP_NONE   3'h0
`define FPD_TRAP_ILL    3'h4

// Byte lengths
`define FPD_LEN_0       4'h0
`define FPD_LEN_1       4'h1
`define FPD_LEN_2       4'h2
`define FPD_LEN_4       4'h4
`define FPD_LEN_8       4'h8

// Response word layout
`define FPD_RSP_SEL     0
`define FPD_RSP_ILL     1
`define FPD_RSP_INV     2
`define FPD_RSP_TT_LSB  3
`define FPD_RSP_TT_MSB  5
`define FPD_RSP_G1_ON   6
`define FPD_RSP_G2_ON   7
`define FPD_RSP_G1_HOST 8
`define FPD_RSP_G2_HOST 9
`define FPD_RSP_G1_IMM  10
`define FPD_RSP_G2_IMM  11
`define FPD_RSP_L1_LSB  12
`define FPD_RSP_L1_MSB  15
`define FPD_RSP_L2_LSB  16
`define FPD_RSP_L2_MSB  19
`define FPD_RSP_K_LSB   20
`define FPD_RSP_K_MSB   23

// Host register offsets
`define FPD_REG_CMD     8'h00
`define FPD_REG_EXT     8'h04
`define FPD_REG_STATUS  8'h08
`define FPD_REG_RESULT  8'h0C

`endif

// *** logic/fpd_pkg.sv ***
// Types shared by the decoder and its host
package fpd_pkg;

  typedef enum logic [3:0] {
    FPD_KIND_NONE       = 4'h0,
    FPD_KIND_COPY       = 4'h1,
    FPD_KIND_D2S        = 4'h2,
    FPD_KIND_S2D        = 4'h3,
    FPD_KIND_I2F        = 4'h4,
    FPD_KIND_RND        = 4'h5,
    FPD_KIND_TRN        = 4'h6,
    FPD_KIND_FLR        = 4'h7,
    FPD_KIND_ARITH      = 4'h8,
    FPD_KIND_FSR_LD     = 4'h9,
    FPD_KIND_FSR_ST     = 4'hA
  } fpd_kind_t;

  typedef enum logic [2:0] {
    FPD_CLS_ONCHIP      = 3'h0,
    FPD_CLS_HOSTREG     = 3'h1,
    FPD_CLS_IMM         = 3'h2,
    FPD_CLS_MEM         = 3'h3,
    FPD_CLS_RSVD        = 3'h4,
    FPD_CLS_UNUSED      = 3'h5
  } fpd_cls_t;

  typedef struct packed {
    fpd_cls_t   cls;
    logic [2:0] idx;
    logic [3:0] len;
    logic       scaled;
    logic       bad_dst;
  } fpd_opnd_t;

endpackage

// *** logic/fpd_link_if.sv ***
// Link between the host controller and the instruction decoder
`timescale 1ns/1ps
interface fpd_link_if (
  input wire logic pclk,
  input wire logic presetn
);
  logic        strobe;
  logic [1:0]  st;
  logic [15:0] wdata;
  logic        rsp_valid;
  logic [31:0] rsp;

  modport host (
    output strobe,
    output st,
    output wdata,
    input  rsp_valid,
    input  rsp
  );

  modport dev (
    input  strobe,
    input  st,
    input  wdata,
    output rsp_valid,
    output rsp
  );
endinterface

// *** logic/fpd_decoder.sv ***
// Coprocessor instruction field decoder, device end of the link
//
// Behaviour
// - Extract two 5-bit mode fields separately
// - Immediates and host-supplied operands reach the coprocessor
// - Modes 11100-11111 mean scale one to eight
// - Immediate length from opcode, MSB first
// - Modes 0-7 float registers or host registers
// - Mode 10100 immediate, never a destination
// - Host resolves all memory operand modes
// - Mode 10011 reserved, never valid
// - Scaled index not on immediate or scaled
// - Recognise only formats nine and eleven
// - Size field byte 00 word 01 dword 11
// - Precision bit one single, zero double
// - Result to second operand, first untouched
// - Decode move and conversion op codes
// - Check precision and size of precision moves
// - Index bytes first, then operand extensions
// - Displacement length in leading bits, signed
// - Operation word arrives byte swapped
// - Two illegal forms give trap code 100
`timescale 1ns/1ps
`include "fpd_consts.svh"

module fpd_decoder
  import fpd_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  fpd_link_if.dev         lnk,
  output logic            dec_valid,
  output fpd_kind_t       dec_kind,
  output fpd_opnd_t       dec_g1,
  output fpd_opnd_t       dec_g2,
  output logic            dec_writes_g2,
  output logic            dec_illegal,
  output logic            dec_invalid,
  output logic [2:0]      dec_trap_type
);

  function automatic logic [3:0] int_len(input logic [1:0] isz);
    case (isz)
      `FPD_I_BYTE:  int_len = `FPD_LEN_1;
      `FPD_I_WORD:  int_len = `FPD_LEN_2;
      `FPD_I_DWORD: int_len = `FPD_LEN_4;
      default:      int_len = `FPD_LEN_0;
    endcase
  endfunction

  function automatic logic [3:0] flt_len(input logic fbit);
    flt_len = (fbit == `FPD_F_SINGLE) ? `FPD_LEN_4 : `FPD_LEN_8;
  endfunction

  function automatic fpd_opnd_t opnd_dec(
    input logic [4:0] mode,
    input logic       used,
    input logic       is_flt,
    input logic [3:0] len,
    input logic       written
  );
    fpd_opnd_t o;
    o = '0;
    o.idx = mode[2:0];
    o.len = len;
    o.scaled = (mode >= `FPD_MODE_SCALE_MIN);
    if (!used) begin
      o.cls = FPD_CLS_UNUSED;
      o.len = `FPD_LEN_0;
    end else if (mode <= `FPD_MODE_REG_MAX) begin
      o.cls = is_flt ? FPD_CLS_ONCHIP : FPD_CLS_HOSTREG;
    end else if (mode == `FPD_MODE_IMM) begin
      o.cls = FPD_CLS_IMM;
      o.bad_dst = written;
    end else if (mode == `FPD_MODE_RSVD) begin
      o.cls = FPD_CLS_RSVD;
    end else begin
      o.cls = FPD_CLS_MEM;
    end
    return o;
  endfunction

  logic        sel_r;
  logic        fmt11_r;
  logic [15:0] opw;
  logic [4:0]  g1_mode;
  logic [4:0]  g2_mode;
  logic [2:0]  op9;
  logic [3:0]  op11;
  logic [1:0]  isz;
  logic        fbit;
  logic        g1_used;
  logic        g2_used;
  logic        g1_flt;
  logic        g2_flt;
  logic [3:0]  g1_len;
  logic [3:0]  g2_len;
  logic        g2_wr;
  logic        enc_bad;
  logic        ill_nxt;
  logic        inv_nxt;
  fpd_kind_t   kind_nxt;
  fpd_opnd_t   g1_nxt;
  fpd_opnd_t   g2_nxt;
  logic [31:0] rsp_nxt;

  assign opw = {lnk.wdata[7:0], lnk.wdata[15:8]};
  assign g1_mode = opw[`FPD_G1_MSB:`FPD_G1_LSB];
  assign g2_mode = opw[`FPD_G2_MSB:`FPD_G2_LSB];
  assign op9 = opw[`FPD_OP9_MSB:`FPD_OP9_LSB];
  assign op11 = opw[`FPD_OP11_MSB:`FPD_OP11_LSB];
  assign isz = opw[`FPD_I_MSB:`FPD_I_LSB];
  assign fbit = fmt11_r ? opw[`FPD_F11_BIT] : opw[`FPD_F9_BIT];

  always_comb begin
    kind_nxt = FPD_KIND_NONE;
    g1_used = 1'b1;
    g2_used = 1'b1;
    g1_flt = 1'b1;
    g2_flt = 1'b1;
    g1_len = flt_len(fbit);
    g2_len = flt_len(fbit);
    g2_wr = 1'b1;
    enc_bad = 1'b0;
    ill_nxt = 1'b0;
    if (fmt11_r) begin
      case (op11)
        `FPD_OP11_COPY: begin
          kind_nxt = FPD_KIND_COPY;
        end
        `FPD_OP11_CMP: begin
          kind_nxt = FPD_KIND_ARITH;
          g2_wr = 1'b0;
        end
        `FPD_OP11_ILL_A, `FPD_OP11_ILL_B: begin
          ill_nxt = 1'b1;
        end
        default: begin
          kind_nxt = FPD_KIND_ARITH;
        end
      endcase
    end else begin
      case (op9)
        `FPD_OP9_I2F: begin
          kind_nxt = FPD_KIND_I2F;
          g1_flt = 1'b0;
          g1_len = int_len(isz);
          enc_bad = (isz == `FPD_I_D2S);
        end
        `FPD_OP9_D2S: begin
          kind_nxt = FPD_KIND_D2S;
          g1_len = `FPD_LEN_8;
          g2_len = `FPD_LEN_4;
          enc_bad = (fbit != `FPD_F_SINGLE) || (isz != `FPD_I_D2S);
        end
        `FPD_OP9_S2D: begin
          kind_nxt = FPD_KIND_S2D;
          g1_len = `FPD_LEN_4;
          g2_len = `FPD_LEN_8;
          enc_bad = (fbit != `FPD_F_DOUBLE) || (isz != `FPD_I_DWORD);
        end
        `FPD_OP9_RND, `FPD_OP9_TRN, `FPD_OP9_FLR: begin
          kind_nxt = (op9 == `FPD_OP9_RND) ? FPD_KIND_RND :
                     (op9 == `FPD_OP9_TRN) ? FPD_KIND_TRN : FPD_KIND_FLR;
          g2_flt = 1'b0;
          g2_len = int_len(isz);
          enc_bad = (isz == `FPD_I_D2S);
        end
        `FPD_OP9_FSR_LD: begin
          kind_nxt = FPD_KIND_FSR_LD;
          g1_flt = 1'b0;
          g1_len = `FPD_LEN_4;
          g2_used = 1'b0;
          g2_wr = 1'b0;
        end
        default: begin
          kind_nxt = FPD_KIND_FSR_ST;
          g2_flt = 1'b0;
          g2_len = `FPD_LEN_4;
          g1_used = 1'b0;
        end
      endcase
    end
  end

  // First operand is only ever read, second takes the result
  assign g1_nxt = opnd_dec(g1_mode, g1_used, g1_flt, g1_len, 1'b0);
  assign g2_nxt = opnd_dec(g2_mode, g2_used, g2_flt, g2_len, g2_wr);
  assign inv_nxt = !ill_nxt &&
                   (enc_bad || g2_nxt.bad_dst ||
                    (g1_nxt.cls == FPD_CLS_RSVD) ||
                    (g2_nxt.cls == FPD_CLS_RSVD));

  always_comb begin
    rsp_nxt = 32'h0000_0000;
    rsp_nxt[`FPD_RSP_SEL] = sel_r;
    if (sel_r) begin
      rsp_nxt[`FPD_RSP_ILL] = ill_nxt;
      rsp_nxt[`FPD_RSP_INV] = inv_nxt;
      rsp_nxt[`FPD_RSP_TT_MSB:`FPD_RSP_TT_LSB] =
        ill_nxt ? `FPD_TRAP_ILL : `FPD_TRAP_NONE;
      rsp_nxt[`FPD_RSP_G1_ON] = (g1_nxt.cls == FPD_CLS_ONCHIP);
      rsp_nxt[`FPD_RSP_G2_ON] = (g2_nxt.cls == FPD_CLS_ONCHIP);
      // Host supplies host-register and memory operands, not immediates
      rsp_nxt[`FPD_RSP_G1_HOST] = (g1_nxt.cls == FPD_CLS_HOSTREG) ||
                                  (g1_nxt.cls == FPD_CLS_MEM);
      rsp_nxt[`FPD_RSP_G2_HOST] = (g2_nxt.cls == FPD_CLS_HOSTREG) ||
                                  (g2_nxt.cls == FPD_CLS_MEM);
      rsp_nxt[`FPD_RSP_G1_IMM] = (g1_nxt.cls == FPD_CLS_IMM);
      rsp_nxt[`FPD_RSP_G2_IMM] = (g2_nxt.cls == FPD_CLS_IMM);
      rsp_nxt[`FPD_RSP_L1_MSB:`FPD_RSP_L1_LSB] = g1_nxt.len;
      rsp_nxt[`FPD_RSP_L2_MSB:`FPD_RSP_L2_LSB] = g2_nxt.len;
      rsp_nxt[`FPD_RSP_K_MSB:`FPD_RSP_K_LSB] = kind_nxt;
    end
  end

  // Selection by identification byte; another byte cancels it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_r <= 1'b0;
      fmt11_r <= 1'b0;
    end else if (lnk.strobe && lnk.st == `FPD_ST_ID) begin
      sel_r <= (lnk.wdata[7:0] == `FPD_ID_FMT9) ||
               (lnk.wdata[7:0] == `FPD_ID_FMT11);
      fmt11_r <= (lnk.wdata[7:0] == `FPD_ID_FMT11);
    end else if (lnk.strobe && lnk.st == `FPD_ST_OPND) begin
      sel_r <= 1'b0;
    end
  end

  // Response to the host, one cycle after the operation word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lnk.rsp_valid <= 1'b0;
      lnk.rsp <= 32'h0000_0000;
    end else begin
      lnk.rsp_valid <= lnk.strobe && (lnk.st == `FPD_ST_OPND);
      if (lnk.strobe && lnk.st == `FPD_ST_OPND) begin
        lnk.rsp <= rsp_nxt;
      end
    end
  end

  // Decoded fields on the user side
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dec_valid <= 1'b0;
      dec_kind <= FPD_KIND_NONE;
      dec_g1 <= '0;
      dec_g2 <= '0;
      dec_writes_g2 <= 1'b0;
      dec_illegal <= 1'b0;
      dec_invalid <= 1'b0;
      dec_trap_type <= `FPD_TRAP_NONE;
    end else begin
      dec_valid <= lnk.strobe && (lnk.st == `FPD_ST_OPND) && sel_r;
      if (lnk.strobe && lnk.st == `FPD_ST_OPND && sel_r) begin
        dec_kind <= kind_nxt;
        dec_g1 <= g1_nxt;
        dec_g2 <= g2_nxt;
        dec_writes_g2 <= g2_wr;
        dec_illegal <= ill_nxt;
        dec_invalid <= inv_nxt;
        dec_trap_type <= ill_nxt ? `FPD_TRAP_ILL : `FPD_TRAP_NONE;
      end
    end
  end

endmodule // fpd_decoder

// *** logic/fpd_host.sv ***
// Host end: APB-programmed issuer of coprocessor instructions
`timescale 1ns/1ps
`include "fpd_consts.svh"

module fpd_host
  import fpd_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  fpd_link_if.host               lnk
);

  if (ADDR_W < 4 || ADDR_W > 8) begin : g_bad_addr_w
    $error("fpd_host: ADDR_W must be 4 to 8");
  end

  typedef enum logic [1:0] {
    FPD_H_IDLE = 2'b00,
    FPD_H_ID   = 2'b01,
    FPD_H_OP   = 2'b10,
    FPD_H_WAIT = 2'b11
  } fpd_hstate_t;

  function automatic logic [3:0] scale_of(input logic [4:0] mode);
    scale_of = (mode >= `FPD_MODE_SCALE_MIN) ?
               (4'h1 << mode[1:0]) : 4'h0;
  endfunction

  function automatic logic idx_bad(input logic [4:0] mode,
                                   input logic [7:0] ibyte);
    idx_bad = (mode >= `FPD_MODE_SCALE_MIN) &&
              ((ibyte[7:3] == `FPD_MODE_IMM) ||
               (ibyte[7:3] >= `FPD_MODE_SCALE_MIN));
  endfunction

  fpd_hstate_t state_r;
  logic [7:0]  id_r;
  logic [15:0] opw_r;
  logic [23:0] ext_r;
  logic        done_r;
  logic [31:0] result_r;
  logic [7:0]  addr;
  logic        wr_acc;
  logic        busy;
  logic [3:0]  disp_len;
  logic [7:0]  disp_val;
  logic [31:0] status;

  assign addr = 8'(paddr);
  assign wr_acc = psel && penable && pwrite;
  assign busy = (state_r != FPD_H_IDLE);
  assign pready = 1'b1;

  // Extension register holds index bytes ahead of the displacement
  // Leading displacement bits give its length, rest is signed
  always_comb begin
    disp_len = ext_r[23] ? (ext_r[22] ? `FPD_LEN_4 : `FPD_LEN_2)
                         : `FPD_LEN_1;
    disp_val = {ext_r[22], ext_r[22:16]};
  end

  always_comb begin
    status = 32'h0000_0000;
    status[0] = busy;
    status[1] = done_r;
    status[2] = idx_bad(opw_r[`FPD_G1_MSB:`FPD_G1_LSB], ext_r[7:0]) ||
                idx_bad(opw_r[`FPD_G2_MSB:`FPD_G2_LSB], ext_r[15:8]);
    status[7:4] = scale_of(opw_r[`FPD_G1_MSB:`FPD_G1_LSB]);
    status[11:8] = scale_of(opw_r[`FPD_G2_MSB:`FPD_G2_LSB]);
    status[15:12] = disp_len;
    status[23:16] = disp_val;
  end

  always_comb begin
    prdata = 32'h0000_0000;
    pslverr = 1'b0;
    case (addr)
      `FPD_REG_CMD:    prdata = {8'h00, id_r, opw_r};
      `FPD_REG_EXT:    prdata = {8'h00, ext_r};
      `FPD_REG_STATUS: prdata = status;
      `FPD_REG_RESULT: prdata = result_r;
      default:         pslverr = psel && penable;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      id_r <= 8'h00;
      opw_r <= 16'h0000;
    end else if (wr_acc && addr == `FPD_REG_CMD && !busy) begin
      id_r <= pwdata[23:16];
      opw_r <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_r <= 24'h00_0000;
    end else if (wr_acc && addr == `FPD_REG_EXT) begin
      ext_r <= pwdata[23:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= FPD_H_IDLE;
    end else begin
      case (state_r)
        FPD_H_IDLE: begin
          if (wr_acc && addr == `FPD_REG_CMD) begin
            state_r <= FPD_H_ID;
          end
        end
        FPD_H_ID:   state_r <= FPD_H_OP;
        FPD_H_OP:   state_r <= FPD_H_WAIT;
        FPD_H_WAIT: begin
          if (lnk.rsp_valid) begin
            state_r <= FPD_H_IDLE;
          end
        end
        default:    state_r <= FPD_H_IDLE;
      endcase
    end
  end

  // Done is set by the answer and cleared by a new command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_r <= 1'b0;
      result_r <= 32'h0000_0000;
    end else if (state_r == FPD_H_WAIT && lnk.rsp_valid) begin
      done_r <= 1'b1;
      result_r <= lnk.rsp;
    end else if (wr_acc && addr == `FPD_REG_CMD && !busy) begin
      done_r <= 1'b0;
    end
  end

  assign lnk.strobe = (state_r == FPD_H_ID) || (state_r == FPD_H_OP);
  assign lnk.st = (state_r == FPD_H_ID) ? `FPD_ST_ID : `FPD_ST_OPND;
  assign lnk.wdata = (state_r == FPD_H_ID) ? {8'h00, id_r} :
                     (state_r == FPD_H_OP) ? {opw_r[7:0], opw_r[15:8]} :
                     16'h0000;

endmodule // fpd_host

// *** verification/fpd_link_chk.sv ***
// Link checker between host and decoder
`timescale 1ns/1ps
`include "fpd_consts.svh"

module fpd_link_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        strobe,
  input wire logic [1:0]  st,
  input wire logic [15:0] wdata,
  input wire logic        rsp_valid,
  input wire logic [31:0] rsp
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_id;
    strobe && st == `FPD_ST_ID;
  endsequence
  sequence s_op;
    strobe && st == `FPD_ST_OPND;
  endsequence
  sequence s_id_ok;
    s_id and (wdata[7:0] == `FPD_ID_FMT9 || wdata[7:0] == `FPD_ID_FMT11);
  endsequence
  sequence s_id_bad;
    s_id and wdata[7:0] != `FPD_ID_FMT9 && wdata[7:0] != `FPD_ID_FMT11;
  endsequence

  chk_id_then_op: assert property (s_id |=> s_op)
    else $error("id byte not followed by op word");
  chk_id_upper_zero: assert property (s_id |-> wdata[15:8] == 8'h00)
    else $error("id byte upper lines not zero");
  chk_rsp_follows_op: assert property (s_op |=> rsp_valid)
    else $error("no answer one cycle after op word");
  chk_rsp_cause: assert property (rsp_valid |-> $past(strobe) &&
    $past(st) == `FPD_ST_OPND) else $error("answer without op word");
  chk_rsp_holds: assert property (!rsp_valid |-> $stable(rsp))
    else $error("answer word changed without valid");
  chk_sel_known: assert property (s_id_ok ##1 s_op |=> rsp[0])
    else $error("known format not selected");
  chk_sel_other: assert property (s_id_bad ##1 s_op |=>
    rsp == 32'h00000000) else $error("other format answered");
  chk_ill_trap: assert property (rsp_valid && rsp[1] |->
    rsp[5:3] == `FPD_TRAP_ILL) else $error("illegal without trap code");
  chk_imm_dst: assert property (rsp_valid && rsp[11] &&
    rsp[23:20] == 4'h1 |-> rsp[2]) else $error("immediate dest accepted");
  cov_sel: cover property (s_id_ok ##1 s_op);
endmodule // fpd_link_chk

// *** verification/tb_top.sv ***
// Bench for host and decoder joined by the link
`timescale 1ns/1ps
`include "fpd_consts.svh"

module tb_top;
  import fpd_pkg::*;
  logic        pclk = 0;
  logic        presetn = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        dec_valid;
  fpd_kind_t   dec_kind;
  fpd_opnd_t   dec_g1;
  fpd_opnd_t   dec_g2;
  logic        dec_writes_g2;
  logic        dec_illegal;
  logic        dec_invalid;
  logic [2:0]  dec_trap_type;
  int          bad_count = 0;
  int          n_tests = 0;
  int          n_dec = 0;
  int          cyc = 0;
  logic [31:0] q;
  logic        e;

  always #5 pclk = ~pclk;

  fpd_link_if fpd_link_if_inst (.pclk(pclk), .presetn(presetn));
  fpd_host fpd_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lnk(fpd_link_if_inst));
  fpd_decoder fpd_decoder_inst (.pclk(pclk), .presetn(presetn),
    .lnk(fpd_link_if_inst), .dec_valid(dec_valid), .dec_kind(dec_kind),
    .dec_g1(dec_g1), .dec_g2(dec_g2), .dec_writes_g2(dec_writes_g2),
    .dec_illegal(dec_illegal), .dec_invalid(dec_invalid),
    .dec_trap_type(dec_trap_type));
  fpd_link_chk fpd_link_chk_inst (.pclk(pclk), .presetn(presetn),
    .strobe(fpd_link_if_inst.strobe), .st(fpd_link_if_inst.st),
    .wdata(fpd_link_if_inst.wdata), .rsp_valid(fpd_link_if_inst.rsp_valid),
    .rsp(fpd_link_if_inst.rsp));

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (dec_valid === 1'b1) n_dec <= n_dec + 1;
    if (cyc > 6000) begin
      bad_count++;
      close_out();
    end
  end

  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] g);
    n_tests++;
    if (g !== x) begin
      $display("wrong value %s exp %h got %h", nm, x, g);
      bad_count++;
    end
  endtask

  // One APB transfer, answer taken at the completing edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rq,
                     output logic re);
    logic fin;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    fin = 1'b0;
    while (!fin) begin
      @(posedge pclk);
      fin = (pready === 1'b1);
      rq = prdata;
      re = pslverr;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Operand class bits {imm, host, onchip}
  function automatic logic [2:0] cls3(input logic [4:0] m, input logic u,
                                      input logic fl);
    if (!u || m == 5'h13) return 3'b000;
    if (m == 5'h14) return 3'b100;
    if (m <= 5'h07 && fl) return 3'b001;
    return 3'b010;
  endfunction

  function automatic logic [31:0] exp_rsp(input logic [7:0] id,
                                          input logic [15:0] w);
    logic [31:0] r;
    logic [3:0]  k, l1, l2, il, fl;
    logic        f1, f2, u1, u2, wr, inv;
    logic [2:0]  c1, c2;
    if (id != 8'h3E && id != 8'hBE) return 32'h00000000;
    il = (w[1:0] == 2'h0) ? 4'h1 : (w[1:0] == 2'h1) ? 4'h2 : 4'h4;
    u1 = 1; u2 = 1; wr = 1; inv = 0; f1 = 1; f2 = 1;
    if (id == 8'hBE) begin
      if (w[5:2] == 4'h3 || w[5:2] == 4'h9) return 32'h00000023;
      fl = w[0] ? 4'h4 : 4'h8;
      l1 = fl; l2 = fl;
      k = (w[5:2] == 4'h1) ? 4'h1 : 4'h8;
      wr = (w[5:2] != 4'h2);
    end else begin
      fl = w[2] ? 4'h4 : 4'h8;
      case (w[5:3])
        3'h0: begin k = 4; f1 = 0; l1 = il; l2 = fl; inv = w[1:0] == 2; end
        3'h1: begin k = 9; f1 = 0; l1 = 4; u2 = 0; l2 = 0; wr = 0; end
        3'h2: begin k = 2; l1 = 8; l2 = 4; inv = !(w[2] && w[1:0] == 2); end
        3'h3: begin k = 3; l1 = 4; l2 = 8; inv = !(!w[2] && w[1:0] == 3); end
        3'h6: begin k = 10; u1 = 0; l1 = 0; f2 = 0; l2 = 4; end
        default: begin
          k = (w[5:3] == 4) ? 5 : (w[5:3] == 5) ? 6 : 7;
          f2 = 0; l1 = fl; l2 = il; inv = w[1:0] == 2;
        end
      endcase
    end
    inv = inv | (u1 && w[15:11] == 5'h13) | (u2 && w[10:6] == 5'h13);
    inv = inv | (u2 && wr && w[10:6] == 5'h14);
    c1 = cls3(w[15:11], u1, f1);
    c2 = cls3(w[10:6], u2, f2);
    r = 32'h00000001;
    r[2] = inv;
    {r[10], r[8], r[6]} = c1;
    {r[11], r[9], r[7]} = c2;
    r[15:12] = l1; r[19:16] = l2; r[23:20] = k;
    return r;
  endfunction

  // Issue one instruction, wait for done, compare the answer word
  task automatic run(input logic [7:0] id, input logic [15:0] w,
                     input logic [31:0] msk);
    logic [31:0] x;
    int n;
    int d0;
    x = exp_rsp(id, w);
    d0 = n_dec;
    apb(1'b1, `FPD_REG_CMD, {8'h00, id, w}, q, e);
    n = 0;
    q = 32'h00000000;
    while (q[1] !== 1'b1 && n < 20) begin
      apb(1'b0, `FPD_REG_STATUS, 32'h00000000, q, e);
      n++;
    end
    chk("done", 32'h00000001, {31'h0, q[1]});
    apb(1'b0, `FPD_REG_RESULT, 32'h00000000, q, e);
    chk("result", x & msk, q & msk);
    chk("dec_valid", {31'h0, x[0]}, n_dec - d0);
    if (x[0]) begin
      chk("dec_trap", {27'h0, x[5:1]},
          {27'h0, dec_trap_type, dec_invalid, dec_illegal});
    end
    if (x[0] && !x[1] && msk[23]) begin
      chk("dec_kind", {28'h0, x[23:20]}, {28'h0, dec_kind});
      chk("dec_writes_g2", {31'h0, x[23:20] != 4'h9 &&
          !(id == 8'hBE && w[5:2] == 4'h2)}, {31'h0, dec_writes_g2});
      chk("dec_len", {24'h0, x[19:12]},
          {24'h0, dec_g2.len, dec_g1.len});
      chk("dec_scaled", {31'h0, w[15:11] >= 5'h1C},
          {31'h0, dec_g1.scaled});
    end
  endtask

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h10, 32'h00000000, q, e);
    chk("unmapped err", 32'h00000001, {31'h0, e});
    chk("unmapped data", 32'h00000000, q);
    run(8'hBE, {5'h02, 5'h03, 4'h1, 1'b0, 1'b1}, 32'hFFFFFFFF);
    run(8'hBE, {5'h14, 5'h08, 4'h1, 1'b0, 1'b0}, 32'hFFFFFFFF);
    run(8'hBE, {5'h01, 5'h14, 4'h1, 1'b0, 1'b1}, 32'h00000007);
    run(8'hBE, {5'h01, 5'h02, 4'h3, 1'b0, 1'b1}, 32'h0000003F);
    run(8'hBE, {5'h01, 5'h02, 4'h9, 1'b0, 1'b1}, 32'h0000003F);
    run(8'hBE, {5'h13, 5'h02, 4'h1, 1'b0, 1'b1}, 32'h00000007);
    run(8'h3E, {5'h01, 5'h00, 3'h0, 1'b1, 2'h0}, 32'hFFFFFFFF);
    run(8'h3E, {5'h17, 5'h00, 3'h0, 1'b0, 2'h1}, 32'hFFFFFFFF);
    run(8'h3E, {5'h01, 5'h00, 3'h0, 1'b1, 2'h3}, 32'hFFFFFFFF);
    run(8'h3E, {5'h00, 5'h01, 3'h2, 1'b1, 2'h2}, 32'hFFFFFFFF);
    run(8'h3E, {5'h00, 5'h01, 3'h2, 1'b0, 2'h2}, 32'h00000007);
    run(8'h3E, {5'h00, 5'h01, 3'h3, 1'b0, 2'h3}, 32'hFFFFFFFF);
    run(8'h3E, {5'h00, 5'h01, 3'h3, 1'b1, 2'h3}, 32'h00000007);
    for (int i = 4; i < 8; i++) begin
      if (i != 6) run(8'h3E, {5'h04, 5'h05, i[2:0], 1'b1, 2'h3}, '1);
    end
    run(8'hBE, {5'h01, 5'h14, 4'h2, 1'b0, 1'b1}, 32'hFFFFFFFF);
    run(8'h3E, {5'h01, 5'h00, 3'h1, 1'b0, 2'h3}, 32'hFFFFFFFF);
    run(8'h3E, {5'h00, 5'h02, 3'h6, 1'b0, 2'h0}, 32'hFFFFFFFF);
    run(8'h1E, {5'h00, 5'h01, 4'h1, 1'b0, 1'b1}, 32'hFFFFFFFF);
    run(8'hBF, {5'h00, 5'h01, 4'h1, 1'b0, 1'b1}, 32'hFFFFFFFF);
    apb(1'b1, `FPD_REG_EXT, 32'h007F00A1, q, e);
    run(8'hBE, {5'h1D, 5'h01, 4'h1, 1'b0, 1'b1}, 32'hFFFFFFFF);
    apb(1'b0, `FPD_REG_STATUS, 32'h00000000, q, e);
    chk("scale", 32'h00000002, {28'h0, q[7:4]});
    chk("index err", 32'h00000001, {31'h0, q[2]});
    chk("disp len", 32'h00000001, {28'h0, q[15:12]});
    chk("disp val", 32'h000000FF, {24'h0, q[23:16]});
    apb(1'b1, `FPD_REG_EXT, 32'h00800009, q, e);
    run(8'hBE, {5'h1D, 5'h01, 4'h1, 1'b0, 1'b1}, 32'hFFFFFFFF);
    apb(1'b0, `FPD_REG_STATUS, 32'h00000000, q, e);
    chk("index ok", 32'h00000000, {31'h0, q[2]});
    chk("disp len", 32'h00000002, {28'h0, q[15:12]});
    close_out();
  end
endmodule // tb_top
